// ### logic/txcc_pkg.sv
// Constants for the transmit channel command controller.
// Assumes a 32-bit APB register bus and octet-wide time slots.
package txcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_CFG  = 8'h04;
  localparam logic [7:0] OFF_FTDP = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  // Command codes {clear, fast, off, abort, jump, init}
  localparam logic [2:0] CMD_CLEAR = 3'h0;
  localparam logic [2:0] CMD_FAST  = 3'h1;
  localparam logic [2:0] CMD_OFF   = 3'h2;
  localparam logic [2:0] CMD_ABORT = 3'h3;
  localparam logic [2:0] CMD_JUMP  = 3'h4;
  localparam logic [2:0] CMD_INIT  = 3'h5;
  // Channel mode field
  localparam logic [1:0] MODE_A    = 2'h0;
  localparam logic [1:0] MODE_BR   = 2'h1;
  localparam logic [1:0] MODE_V110 = 2'h2;
  localparam logic [1:0] MODE_HDLC = 2'h3;
  // Config field positions
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_RMODE   = 2;
  localparam int CFG_IFS     = 3;
  localparam int CFG_FFS     = 4;
  localparam int CFG_LOOP    = 5;
  localparam int CFG_FLAG_LO = 8;
  // Fill and abort octets
  localparam logic [7:0] FILL_7E    = 8'h7e;
  localparam logic [7:0] FILL_FF    = 8'hff;
  localparam logic [7:0] FILL_00    = 8'h00;
  localparam logic [7:0] HDLC_AB_HI = 8'h7f;
  localparam logic [7:0] V110_BADSY = 8'h80;
  // Abort lengths in octets
  localparam logic [5:0] LEN_HDLC   = 6'h02;
  localparam logic [5:0] LEN_B      = 6'h01;
  localparam logic [5:0] LEN_R      = 6'h02;
  localparam logic [5:0] LEN_A      = 6'h01;
  localparam int         V110_FRMS  = 3;
  localparam int         V110_FLEN  = 10;
  typedef enum logic [2:0] {F_INIT, F_OFF, F_FILL1, F_DATA, F_ABSEQ, F_ABFILL} txcc_fst_e;
endpackage : txcc_pkg

// ### logic/txcc_fill.sv
// Fill and abort octet selection per protocol mode.
// Purely combinational; inputs from the config register, first from the abort sequencer.
`timescale 1ns/1ns
`default_nettype none
module txcc_fill
  import txcc_pkg::*;
(
  input  wire logic [1:0] mode,
  input  wire logic       rmode,
  input  wire logic       ifs,
  input  wire logic       ffs,
  input  wire logic [7:0] flag,
  input  wire logic       first,
  output logic      [7:0] fill_byte,
  output logic      [7:0] abort_byte,
  output logic      [5:0] abort_len
);
  logic [7:0] a_fill;

  assign a_fill = ffs ? flag : FILL_FF;

  always_comb
  begin
    case (mode)
      MODE_HDLC:
      begin
        fill_byte  = ifs ? FILL_FF : FILL_7E;
        abort_byte = first ? HDLC_AB_HI : FILL_FF;
        abort_len  = LEN_HDLC;
      end
      MODE_BR:
      begin
        fill_byte  = FILL_00;
        abort_byte = FILL_00;
        abort_len  = rmode ? LEN_R : LEN_B;
      end
      MODE_V110:
      begin
        fill_byte  = FILL_00;
        abort_byte = V110_BADSY;
        abort_len  = 6'(V110_FRMS * V110_FLEN);
      end
      default:
      begin
        fill_byte  = a_fill;
        abort_byte = a_fill;
        abort_len  = LEN_A;
      end
    endcase
  end
endmodule : txcc_fill
`default_nettype wire

// ### logic/txcc_seq.sv
// Abort sequence octet counter, advanced once per time slot.
// Start loads the length; last flags the final octet.
`timescale 1ns/1ns
`default_nettype none
module txcc_seq
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       kill,
  input  wire logic       slot_tick,
  input  wire logic [5:0] len,
  output logic            busy,
  output logic            first,
  output logic            last
);
  logic [5:0] left_reg;
  logic [5:0] done_reg;

  assign busy  = (left_reg != 6'h00);
  assign first = (done_reg == 6'h00);
  assign last  = (left_reg == 6'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_reg <= 6'h00;
      done_reg <= 6'h00;
    end
    else if (kill)
    begin
      left_reg <= 6'h00;
      done_reg <= 6'h00;
    end
    else if (start)
    begin
      // A start on a slot edge spends that slot on the first octet
      left_reg <= slot_tick ? len - 6'h01 : len;
      done_reg <= slot_tick ? 6'h01 : 6'h00;
    end
    else if (slot_tick && busy)
    begin
      left_reg <= left_reg - 6'h01;
      done_reg <= done_reg + 6'h01;
    end
  end
endmodule : txcc_seq
`default_nettype wire

// ### logic/txcc_ctrl.sv
// Transmit channel command controller: APB registers,
// command decode, DMA steering and the time-slot formatter.
// Assumes slot_tick and buffer signals are on pclk.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] Clear drops off/abort once initialized
// [R2] Fast abort: DMA discards, branches at once
// [R3] Append HDLC/B/R abort pattern before next frame
// [R4] V.110: three corrupt-sync 10-octet frames
// [R5] Mode A: flag or FF after suspended data
// [R6] Off resets formatter, stops reads, tristates
// [R7] Loop: off only tristates output; here off_reg also stops buffer reads
// [R8] Non-init exit from off resumes buffer
// [R9] Init exit: fill octet, then new frame
// [R10] Host: V.110 first descriptor carries marker
// [R11] Mode A init exit: flag or FF fill
// [R12] Host sets mode A with every off
// [R13] Abort ends frame with mode sequence
// [R14] Then continuous interframe fill
// [R15] No buffer reads during abort
// [R16] Withdrawn abort resumes as new frame
// [R17] Host drains via hold before stopping
// [R18] Jump branches after current descriptor
// [R19] Open frame continues into new chain
// [R20] Init must come first; silent before it
// [R21] Host gives buffer size 1..63 on init
// [R22] Init in operation affects DMA only
// [R23] Host avoids reserved command codes
module txcc_ctrl
  import txcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slot_tick,
  input  wire logic        buf_valid,
  input  wire logic [7:0]  buf_data,
  input  wire logic        buf_eof,
  input  wire logic        buf_new_chain,
  output logic             buf_rd,
  input  wire logic        last_frame_end,
  output logic [7:0]       tx_data,
  output logic             tx_oe,
  output logic             dma_run,
  output logic             dma_branch,
  output logic             dma_discard,
  output logic             dma_jump,
  output logic             dma_append,
  output logic [31:0]      desc_ptr
);
  logic [2:0]  cmd_reg;
  logic [15:0] cfg_reg;
  logic [31:0] ftdp_reg;
  logic        inited_reg;
  logic        off_reg;
  logic        abort_reg;
  logic        fast_reg;
  logic        fopen_reg;
  txcc_fst_e   fst_reg;
  txcc_fst_e   fst_next;
  logic        wr_go;
  logic        cmd_go;
  logic [2:0]  cmd;
  logic        is_clr;
  logic        is_fast;
  logic        is_off;
  logic        is_abort;
  logic        is_jump;
  logic        is_init;
  logic [1:0]  mode;
  logic        loop;
  logic        fmt_idle;
  logic        inject;
  logic        seq_start;
  logic        seq_busy;
  logic        seq_first;
  logic        seq_last;
  logic [7:0]  fill_byte;
  logic [7:0]  abort_byte;
  logic [5:0]  abort_len;
  logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Zero-wait APB slave
  assign pready  = 1'b1;
  assign wr_go   = psel && penable && pwrite;
  assign cmd_go  = wr_go && hit(paddr, OFF_CMD);
  assign cmd     = pwdata[2:0];
  assign pslverr = psel && penable && !(hit(paddr, OFF_CMD) || hit(paddr, OFF_CFG)
                   || hit(paddr, OFF_FTDP) || hit(paddr, OFF_STAT));

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, OFF_CMD))
      rd_mux[2:0] = cmd_reg;
    else if (hit(paddr, OFF_CFG))
      rd_mux[15:0] = cfg_reg;
    else if (hit(paddr, OFF_FTDP))
      rd_mux = ftdp_reg;
    else if (hit(paddr, OFF_STAT))
      rd_mux[7:0] = {1'b0, fst_reg, fopen_reg, fast_reg, abort_reg, off_reg};
    if (hit(paddr, OFF_STAT))
      rd_mux[8] = inited_reg;
  end

  // Read data captured in setup, stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg  <= CMD_CLEAR;
      cfg_reg  <= 16'h0000;
      ftdp_reg <= 32'h0000_0000;
    end
    else
    begin
      if (cmd_go)
        cmd_reg <= cmd;
      if (wr_go && hit(paddr, OFF_CFG))
        cfg_reg <= pwdata[15:0];
      if (wr_go && hit(paddr, OFF_FTDP))
        ftdp_reg <= pwdata;
    end
  end

  assign mode     = cfg_reg[CFG_MODE_LO +: 2];
  assign loop     = cfg_reg[CFG_LOOP];
  assign desc_ptr = ftdp_reg;
  assign dma_run  = inited_reg;

  // Only init acts before the channel is initialized
  assign is_init  = cmd_go && (cmd == CMD_INIT);
  assign is_clr   = cmd_go && inited_reg && (cmd == CMD_CLEAR);
  assign is_fast  = cmd_go && inited_reg && (cmd == CMD_FAST);
  assign is_off   = cmd_go && inited_reg && (cmd == CMD_OFF);
  assign is_abort = cmd_go && inited_reg && (cmd == CMD_ABORT);
  assign is_jump  = cmd_go && inited_reg && (cmd == CMD_JUMP);

  // Condition flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inited_reg <= 1'b0;
      off_reg    <= 1'b0;
      abort_reg  <= 1'b0;
    end
    else if (is_init)
    begin
      inited_reg <= 1'b1; // R20
      off_reg    <= 1'b0;
      abort_reg  <= 1'b0;
    end
    else if (is_off)
    begin
      off_reg   <= 1'b1; // R6
      abort_reg <= 1'b0;
    end
    else if (is_abort)
    begin
      abort_reg <= 1'b1; // R13
      off_reg   <= 1'b0;
    end
    else if (is_clr || is_fast || is_jump)
    begin
      off_reg   <= 1'b0; // R1
      abort_reg <= 1'b0; // R18
    end
  end

  // DMA steering pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_branch  <= 1'b0;
      dma_discard <= 1'b0;
      dma_jump    <= 1'b0;
      dma_append  <= 1'b0;
    end
    else
    begin
      dma_branch  <= is_fast || is_init; // R2 R22
      dma_discard <= is_fast || is_init; // R2 R22
      dma_jump    <= is_jump; // R18
      dma_append  <= is_jump && !last_frame_end && (mode == MODE_HDLC || mode == MODE_BR); // R19
    end
  end

  // Fast abort marker until the new chain reaches the formatter
  assign inject = (fst_reg == F_DATA) && fast_reg && slot_tick && buf_valid && buf_new_chain;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_reg <= 1'b0;
    else if (is_fast)
      fast_reg <= 1'b1; // R2
    else if (inject || is_init || (is_off && !loop))
      fast_reg <= 1'b0;
  end

  txcc_fill u_fill (
    .mode       (mode),
    .rmode      (cfg_reg[CFG_RMODE]),
    .ifs        (cfg_reg[CFG_IFS]),
    .ffs        (cfg_reg[CFG_FFS]),
    .flag       (cfg_reg[CFG_FLAG_LO +: 8]),
    .first      (seq_first || seq_start),
    .fill_byte  (fill_byte),
    .abort_byte (abort_byte),
    .abort_len  (abort_len)
  );

  assign fmt_idle  = (fst_reg == F_INIT) || (fst_reg == F_OFF);
  assign seq_start = inject || (is_abort && fopen_reg && (fst_reg == F_DATA));

  txcc_seq u_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (seq_start),
    .kill      ((is_off && !loop) || is_init || is_clr || is_jump),
    .slot_tick (slot_tick),
    .len       (abort_len),
    .busy      (seq_busy),
    .first     (seq_first),
    .last      (seq_last)
  );

  // Formatter state sequencing
  always_comb
  begin
    fst_next = fst_reg;
    case (fst_reg)
      F_INIT:
        fst_next = F_INIT;
      F_OFF:
        fst_next = F_OFF;
      F_FILL1:
        if (slot_tick)
          fst_next = F_DATA;
      F_DATA:
        if (inject)
          fst_next = F_ABSEQ; // R3 R4 R5
      F_ABSEQ:
        if (!seq_busy || (slot_tick && seq_last))
          fst_next = abort_reg ? F_ABFILL : F_DATA; // R14
      F_ABFILL:
        fst_next = F_ABFILL;
      default:
        fst_next = F_INIT;
    endcase
    if (is_init && (fmt_idle || abort_reg))
      fst_next = F_FILL1; // R9 R11
    else if (is_off && !loop)
      fst_next = F_OFF; // R6
    else if (is_abort)
      fst_next = seq_start ? F_ABSEQ : F_ABFILL; // R13 R14
    else if ((is_clr || is_fast || is_jump) && fst_reg != F_DATA && fst_reg != F_FILL1)
      fst_next = F_DATA; // R8 R16
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fst_reg <= F_INIT;
    else
      fst_reg <= fst_next;
  end

  // Buffer reads only in data state; never during abort or off
  assign buf_rd = slot_tick && buf_valid && (fst_reg == F_DATA) && !seq_start
                  && !abort_reg && !off_reg; // R15 R6

  // Open frame tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fopen_reg <= 1'b0;
    else if (seq_start || is_init || (is_off && !loop) || fst_reg == F_ABFILL)
      fopen_reg <= 1'b0; // R16
    else if (buf_rd)
      fopen_reg <= !buf_eof;
  end

  // Serial octet and drive enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_data <= FILL_FF;
      tx_oe   <= 1'b0;
    end
    else if (is_off || (off_reg && !is_init && !is_clr && !is_fast && !is_jump && !is_abort))
      tx_oe <= 1'b0; // R6 R7
    else if (slot_tick)
    begin
      tx_oe <= !fmt_idle && !off_reg; // R20
      case (fst_reg)
        F_ABSEQ:
          tx_data <= seq_busy ? abort_byte : fill_byte; // R13
        F_DATA:
          tx_data <= seq_start ? abort_byte : (buf_rd ? buf_data : fill_byte); // R3 R4 R5
        default:
          tx_data <= fill_byte; // R14
      endcase
    end
  end

  a_off_oe: assert property (@(posedge pclk) disable iff (!presetn) // R6
    is_off |=> !tx_oe [*2])
    else $error("drive enable not dropped by off");
  a_off_reset: assert property (@(posedge pclk) disable iff (!presetn) // R6
    is_off && !loop |=> fst_reg == F_OFF && !fopen_reg)
    else $error("formatter not reset by off");
  a_loop_keep: assert property (@(posedge pclk) disable iff (!presetn) // R7
    is_off && loop && (fst_reg == F_ABFILL || (fst_reg == F_DATA && !fast_reg))
    |=> fst_reg == $past(fst_reg) && !tx_oe)
    else $error("loop off changed formatter");
  a_clear_flags: assert property (@(posedge pclk) disable iff (!presetn) // R1
    is_clr |=> !off_reg && !abort_reg)
    else $error("clear left a condition");
  a_fast_dma: assert property (@(posedge pclk) disable iff (!presetn) // R2
    is_fast |=> dma_branch && dma_discard && fast_reg)
    else $error("fast abort not sent to dma");
  a_no_read_abt: assert property (@(posedge pclk) disable iff (!presetn) // R15
    abort_reg |-> !buf_rd)
    else $error("buffer read during abort");
  a_abort_seq: assert property (@(posedge pclk) disable iff (!presetn) // R13
    is_abort && fopen_reg && fst_reg == F_DATA |=> fst_reg == F_ABSEQ && (seq_busy || abort_len == 6'h01))
    else $error("abort sequence not started");
  a_init_fill: assert property (@(posedge pclk) disable iff (!presetn) // R9
    is_init && fmt_idle |=> fst_reg == F_FILL1 && inited_reg)
    else $error("init did not start with fill");
  a_init_dmaonly: assert property (@(posedge pclk) disable iff (!presetn) // R22
    is_init && fst_reg == F_DATA && !abort_reg && !inject |=> fst_reg == F_DATA && dma_discard)
    else $error("init in operation touched formatter");
  a_jump_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R18
    is_jump |=> dma_jump && !dma_branch ##1 !dma_jump)
    else $error("jump pulse wrong");
  a_uninit_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R20
    !inited_reg |-> !tx_oe && !buf_rd && !dma_run)
    else $error("activity before init");

  c_fast_inject: cover property (@(posedge pclk) disable iff (!presetn) inject);
  c_abort_fill:  cover property (@(posedge pclk) disable iff (!presetn)
    fst_reg == F_ABSEQ ##[1:40] fst_reg == F_ABFILL);
  c_off_init:    cover property (@(posedge pclk) disable iff (!presetn)
    fst_reg == F_OFF ##1 fst_reg == F_FILL1);
endmodule : txcc_ctrl
`default_nettype wire

// ### sim/txcc_buf_model.sv
// Transmit buffer stand-in: hands out a counting octet stream.
// Assumes the design's DMA strobes arrive as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module txcc_buf_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       buf_rd,
  input  wire logic       dma_discard,
  input  wire logic       stall,
  output logic            buf_valid,
  output logic      [7:0] buf_data,
  output logic            buf_eof,
  output logic            buf_new_chain
);
  logic [7:0] next_reg;
  logic       fresh_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_reg  <= 8'h10;
      fresh_reg <= 1'b0;
    end
    else if (dma_discard)
    begin
      next_reg  <= 8'h40;
      fresh_reg <= 1'b1;
    end
    else if (buf_rd)
    begin
      next_reg  <= next_reg + 8'h01;
      fresh_reg <= 1'b0;
    end
  end

  // Stalled: data shows junk, never the held octet
  assign buf_valid     = !stall;
  assign buf_data      = stall ? ~next_reg : next_reg;
  assign buf_eof       = &next_reg;
  assign buf_new_chain = fresh_reg & !stall;
endmodule : txcc_buf_model
`default_nettype wire

// ### sim/tx_channel_command_ctrl_tb.sv
// Bench: APB command sequences and time-slot octet checks.
// Assumes the buffer model restarts at 40 after each discard.
`timescale 1ns/1ns
`default_nettype none
module tx_channel_command_ctrl_tb
  import txcc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        slot_tick = 1'b0;
  logic        last_frame_end = 1'b1;
  logic        stall = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        buf_valid;
  logic [7:0]  buf_data;
  logic        buf_eof;
  logic        buf_new_chain;
  logic        buf_rd;
  logic [7:0]  tx_data;
  logic        tx_oe;
  logic        dma_run;
  logic        dma_branch;
  logic        dma_discard;
  logic        dma_jump;
  logic        dma_append;
  logic [31:0] desc_ptr;
  logic [31:0] q;
  logic        e;
  logic [7:0]  d;
  int          n_fail = 0;
  int          total_checks = 0;
  // HDLC, HDLC FF fill, B, R, A flag, A plain, V.110
  logic [31:0] mode_cfg [7] = '{32'h3, 32'hb, 32'h1, 32'h5, 32'h5a10, 32'h0, 32'h2};
  logic [7:0]  first_ab [7] = '{8'h7f, 8'h7f, 8'h00, 8'h00, 8'h5a, 8'hff, 8'h80};
  logic [7:0]  next_ab  [7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h5a, 8'hff, 8'h80};
  logic [7:0]  fill_x   [7] = '{8'h7e, 8'hff, 8'h00, 8'h00, 8'h5a, 8'hff, 8'h00};
  int          ab_len   [7] = '{2, 2, 1, 2, 1, 1, 30};

  txcc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .slot_tick, .buf_valid, .buf_data, .buf_eof, .buf_new_chain,
    .buf_rd, .last_frame_end, .tx_data, .tx_oe, .dma_run, .dma_branch, .dma_discard,
    .dma_jump, .dma_append, .desc_ptr);

  txcc_buf_model u_buf (.pclk, .presetn, .buf_rd, .dma_discard, .stall, .buf_valid,
    .buf_data, .buf_eof, .buf_new_chain);

  initial
  begin
    forever #25 pclk = ~pclk;
  end

  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
  endtask : apb

  // One time slot; octet is checked only while driven
  task automatic tick(input logic [7:0] x, input logic oe);
    @(posedge pclk);
    slot_tick <= 1'b1;
    @(posedge pclk);
    slot_tick <= 1'b0;
    #1;
    chk("tx_oe", 32'(tx_oe), 32'(oe));
    if (oe)
      chk("tx_data", 32'(tx_data), 32'(x));
  endtask : tick

  task automatic cmd(input logic [2:0] c);
    apb(1'b1, OFF_CMD, 32'(c));
  endtask : cmd

  initial
  begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("tx_oe", 32'(tx_oe), 32'h0);
    chk("dma_run", 32'(dma_run), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 32'(e), 32'h1);
    cmd(CMD_OFF);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat", q, 32'h0);
    apb(1'b1, OFF_FTDP, 32'h1000);
    cmd(CMD_INIT);
    #1;
    chk("dma_branch", 32'(dma_branch), 32'h1);
    chk("dma_run", 32'(dma_run), 32'h1);
    chk("desc_ptr", desc_ptr, 32'h1000);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, OFF_CFG, 32'h0);
      stall <= 1'b1;
      cmd(CMD_OFF);
      @(posedge pclk);
      #1;
      chk("tx_oe", 32'(tx_oe), 32'h0);
      tick(8'h00, 1'b0);
      apb(1'b1, OFF_CFG, mode_cfg[i]);
      stall <= 1'b0;
      cmd(CMD_INIT);
      #1;
      chk("dma_discard", 32'(dma_discard), 32'h1);
      tick(fill_x[i], 1'b1);
      tick(8'h40, 1'b1);
    end
    d = 8'h41;
    apb(1'b1, OFF_CFG, 32'h3);
    last_frame_end <= 1'b0;
    cmd(CMD_JUMP);
    #1;
    chk("dma_jump", 32'(dma_jump), 32'h1);
    chk("dma_append", 32'(dma_append), 32'h1);
    tick(d, 1'b1);
    cmd(CMD_INIT);
    tick(8'h40, 1'b1);
    d = 8'h41;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, OFF_CFG, mode_cfg[i]);
      cmd(CMD_ABORT);
      for (int k = 0; k < ab_len[i]; k++)
        tick((k > 0) ? next_ab[i] : first_ab[i], 1'b1);
      tick(fill_x[i], 1'b1);
      tick(fill_x[i], 1'b1);
      cmd(CMD_CLEAR);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("stat_off_abort", q & 32'h3, 32'h0);
      tick(d, 1'b1);
      cmd(CMD_FAST);
      #1;
      chk("dma_discard", 32'(dma_discard), 32'h1);
      for (int k = 0; k < ab_len[i]; k++)
        tick((k > 0) ? next_ab[i] : first_ab[i], 1'b1);
      tick(8'h40, 1'b1);
      d = 8'h41;
    end
    apb(1'b1, OFF_CFG, 32'h20);
    cmd(CMD_OFF);
    @(posedge pclk);
    #1;
    chk("tx_oe", 32'(tx_oe), 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_state", (q >> 4) & 32'h7, 32'h3);
    apb(1'b1, OFF_CFG, 32'h3);
    cmd(CMD_CLEAR);
    tick(d, 1'b1);
    stop_test();
  end
endmodule : tx_channel_command_ctrl_tb
`default_nettype wire
